// >>> imu_defines.svh
// Constants for the integer multiply unit
`ifndef IMU_DEFINES_SVH
`define IMU_DEFINES_SVH
// Instruction fields
`define IMU_OPC_MSB 31
`define IMU_OPC_LSB 24
`define IMU_DST_MSB 23
`define IMU_DST_LSB 16
`define IMU_SRC1_MSB 15
`define IMU_SRC1_LSB 8
`define IMU_SRC2_MSB 7
`define IMU_SRC2_LSB 0
// Opcodes
`define IMU_OPC_MUL_LO 8'he0
`define IMU_OPC_MUL_HI_S 8'hde
`define IMU_OPC_MUL_HI_U 8'hdf
`define IMU_OPC_STEP_REG 8'h74
`define IMU_OPC_STEP_IMM 8'h75
// Register byte addresses
`define IMU_ADDR_CTRL 8'h00
`define IMU_ADDR_STEP_Q 8'h04
`define IMU_ADDR_FLAGS 8'h08
`define IMU_ADDR_IRQ_STAT 8'h0c
`define IMU_ADDR_IRQ_EN 8'h10
`define IMU_ADDR_IRQ_CLR 8'h14
`define IMU_ADDR_IPTR 8'h18
// Field positions
`define IMU_CTRL_HW_MUL 0
`define IMU_FLAG_C 0
`define IMU_FLAG_Z 1
`define IMU_FLAG_N 2
`define IMU_FLAG_V 3
`define IMU_IRQ_TRAP 0
`define IMU_IRQ_STEP 1
`define IMU_IRQ_HWMUL 2
// Reset values and responses
`define IMU_CTRL_RST 1'b0
`define IMU_Q_RST 32'h0000_0000
`define IMU_FLAGS_RST 4'h0
`define IMU_IRQ_RST 3'h0
`define IMU_RESP_OKAY 2'h0
`define IMU_RESP_SLVERR 2'h2
`endif

// >>> imu_pkg.sv
// Types for the integer multiply unit
package imu_pkg;
  typedef enum logic [2:0] {
    IMU_OP_NONE     = 3'h0,
    IMU_OP_MUL_LO   = 3'h1,
    IMU_OP_MUL_HI_S = 3'h2,
    IMU_OP_MUL_HI_U = 3'h3,
    IMU_OP_STEP     = 3'h4
  } imu_op_t;
  typedef enum logic [1:0] {
    IMU_TRAP_MUL_LO   = 2'h0,
    IMU_TRAP_MUL_HI_S = 2'h1,
    IMU_TRAP_MUL_HI_U = 2'h2
  } imu_trap_t;
endpackage

// >>> imu_core.sv
// Integer multiply unit: full-multiply traps, unsigned step, AXI4-Lite regs
`timescale 1ns/1ps
`include "imu_defines.svh"
// Operation
// - signed low-word multiply gives low 32 bits
// - high-word multiplies give upper 32 bits
// - unsigned high-word multiply treats operands unsigned
// - decode E0, DE, DF as full multiplies
// - decode 74 register, 75 immediate step
// - step adds first source when Q bit0 set
// - shift sum:Q right, carry fills top
// - upper half to target, lower to Q
// - Q undefined after full multiplies
// - full multiplies trap instead of computing; here only while hw_mul_r is clear, with it set they compute
// - trap loads pointers with register numbers
module imu_core (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        issue_valid,
  input  wire logic [31:0] issue_instr,
  input  wire logic [31:0] first_source_value,
  input  wire logic [31:0] second_source_value,
  output logic             result_valid,
  output logic [7:0]       result_target,
  output logic [31:0]      result_data,
  output logic             flags_valid,
  output logic [3:0]       flags,
  output logic             trap_valid,
  output logic [1:0]       trap_code,
  output logic [7:0]       indirect_ptr_first,
  output logic [7:0]       indirect_ptr_second,
  output logic [7:0]       indirect_ptr_third,
  output logic             irq
);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Decode and datapath
  imu_pkg::imu_op_t op;
  logic [7:0]       opc;
  logic [7:0]       dst_field;
  logic [7:0]       src1_field;
  logic [7:0]       src2_field;
  logic [31:0]      src2_val;
  logic [31:0]      addend;
  logic [32:0]      step_sum;
  logic [31:0]      step_high;
  logic [31:0]      step_low;
  logic [3:0]       step_flags;
  logic [63:0]      prod_u;
  logic signed [63:0] prod_s;
  logic [31:0]      q_r;
  logic             hw_mul_r;

  assign opc        = issue_instr[`IMU_OPC_MSB:`IMU_OPC_LSB];
  assign dst_field  = issue_instr[`IMU_DST_MSB:`IMU_DST_LSB];
  assign src1_field = issue_instr[`IMU_SRC1_MSB:`IMU_SRC1_LSB];
  assign src2_field = issue_instr[`IMU_SRC2_MSB:`IMU_SRC2_LSB];

  always_comb begin
    if (!issue_valid) begin
      op = imu_pkg::IMU_OP_NONE;
    end else begin
      unique case (opc)
        `IMU_OPC_MUL_LO:   op = imu_pkg::IMU_OP_MUL_LO;
        `IMU_OPC_MUL_HI_S: op = imu_pkg::IMU_OP_MUL_HI_S;
        `IMU_OPC_MUL_HI_U: op = imu_pkg::IMU_OP_MUL_HI_U;
        `IMU_OPC_STEP_REG: op = imu_pkg::IMU_OP_STEP;
        `IMU_OPC_STEP_IMM: op = imu_pkg::IMU_OP_STEP;
        default:           op = imu_pkg::IMU_OP_NONE;
      endcase
    end
  end

  // Immediate form zero-extends the low byte
  assign src2_val = (opc == `IMU_OPC_STEP_IMM) ? {24'h0, src2_field}
                                                : second_source_value;
  assign addend    = q_r[0] ? first_source_value : 32'h0;
  assign step_sum  = {1'b0, addend} + {1'b0, src2_val};
  assign step_high = {step_sum[32], step_sum[31:1]};
  assign step_low  = {step_sum[0], q_r[31:1]};
  assign step_flags[`IMU_FLAG_C] = step_sum[32];
  assign step_flags[`IMU_FLAG_Z] = (step_high == 32'h0);
  assign step_flags[`IMU_FLAG_N] = step_high[31];
  assign step_flags[`IMU_FLAG_V] = (addend[31] == src2_val[31]) &&
                                   (step_sum[31] != src2_val[31]);
  assign prod_u = {32'h0, first_source_value} *
                  {32'h0, second_source_value};
  assign prod_s = $signed({{32{first_source_value[31]}}, first_source_value})
                * $signed({{32{second_source_value[31]}},
                           second_source_value});

  logic is_full;
  assign is_full = (op == imu_pkg::IMU_OP_MUL_LO) ||
                   (op == imu_pkg::IMU_OP_MUL_HI_S) ||
                   (op == imu_pkg::IMU_OP_MUL_HI_U);

  // Results, traps and step outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_valid  <= 1'b0;
      result_target <= 8'h00;
      result_data   <= 32'h0;
      flags_valid   <= 1'b0;
      trap_valid    <= 1'b0;
      trap_code     <= imu_pkg::IMU_TRAP_MUL_LO;
    end else begin
      result_valid <= 1'b0;
      flags_valid  <= 1'b0;
      trap_valid   <= 1'b0;
      unique case (op)
        imu_pkg::IMU_OP_STEP: begin
          result_valid  <= 1'b1;
          result_target <= dst_field;
          result_data   <= step_high;
          flags_valid   <= 1'b1;
        end
        imu_pkg::IMU_OP_MUL_LO: begin
          if (hw_mul_r) begin
            result_valid  <= 1'b1;
            result_target <= dst_field;
            result_data   <= prod_s[31:0];
          end else begin
            trap_valid <= 1'b1;
            trap_code  <= imu_pkg::IMU_TRAP_MUL_LO;
          end
        end
        imu_pkg::IMU_OP_MUL_HI_S: begin
          if (hw_mul_r) begin
            result_valid  <= 1'b1;
            result_target <= dst_field;
            result_data   <= prod_s[63:32];
          end else begin
            trap_valid <= 1'b1;
            trap_code  <= imu_pkg::IMU_TRAP_MUL_HI_S;
          end
        end
        imu_pkg::IMU_OP_MUL_HI_U: begin
          if (hw_mul_r) begin
            result_valid  <= 1'b1;
            result_target <= dst_field;
            result_data   <= prod_u[63:32];
          end else begin
            trap_valid <= 1'b1;
            trap_code  <= imu_pkg::IMU_TRAP_MUL_HI_U;
          end
        end
        imu_pkg::IMU_OP_NONE: begin
        end
      endcase
    end
  end

  // Pointers take the register numbers of a trapping multiply
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      indirect_ptr_first  <= 8'h00;
      indirect_ptr_second <= 8'h00;
      indirect_ptr_third  <= 8'h00;
    end else if (is_full && !hw_mul_r) begin
      indirect_ptr_first  <= src1_field;
      indirect_ptr_second <= src2_field;
      indirect_ptr_third  <= dst_field;
    end
  end

  // Only the step touches flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= `IMU_FLAGS_RST;
    end else if (op == imu_pkg::IMU_OP_STEP) begin
      flags <= step_flags;
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_fire;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_en_r;
  logic [2:0]  irq_set;
  logic [2:0]  irq_clr;
  logic [2:0]  irq_stat_nxt;
  logic [31:0] rd_data;
  logic        rd_err;

  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IMU_RESP_OKAY;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0;
      wstrb_r       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r      <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r      <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        unique case (awaddr_r)
          `IMU_ADDR_CTRL, `IMU_ADDR_STEP_Q, `IMU_ADDR_IRQ_EN,
          `IMU_ADDR_IRQ_CLR: s_axi_bresp <= `IMU_RESP_OKAY;
          default:           s_axi_bresp <= `IMU_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_got_r      <= 1'b0;
        w_got_r       <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_err  = 1'b0;
    rd_data = 32'h0;
    unique case (s_axi_araddr)
      `IMU_ADDR_CTRL:     rd_data = {31'h0, hw_mul_r};
      `IMU_ADDR_STEP_Q:   rd_data = q_r;
      `IMU_ADDR_FLAGS:    rd_data = {28'h0, flags};
      `IMU_ADDR_IRQ_STAT: rd_data = {29'h0, irq_stat_r};
      `IMU_ADDR_IRQ_EN:   rd_data = {29'h0, irq_en_r};
      `IMU_ADDR_IRQ_CLR:  rd_data = 32'h0;
      `IMU_ADDR_IPTR:     rd_data = {8'h00, indirect_ptr_third,
                                     indirect_ptr_first,
                                     indirect_ptr_second};
      default:            rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `IMU_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_err ? `IMU_RESP_SLVERR : `IMU_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Software registers
  logic [31:0] ctrl_merged;
  assign ctrl_merged = merge_bytes({31'h0, hw_mul_r}, wdata_r, wstrb_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hw_mul_r <= `IMU_CTRL_RST;
    end else if (wr_fire && awaddr_r == `IMU_ADDR_CTRL) begin
      hw_mul_r <= ctrl_merged[`IMU_CTRL_HW_MUL];
    end
  end

  // A step in the same cycle as a software write wins; full multiplies
  // leave Q as it was, a legal value for "undefined"
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= `IMU_Q_RST;
    end else if (op == imu_pkg::IMU_OP_STEP) begin
      q_r <= step_low;
    end else if (wr_fire && awaddr_r == `IMU_ADDR_STEP_Q) begin
      q_r <= merge_bytes(q_r, wdata_r, wstrb_r);
    end
  end

  logic [31:0] en_merged;
  assign en_merged = merge_bytes({29'h0, irq_en_r}, wdata_r, wstrb_r);
  assign irq_set[`IMU_IRQ_TRAP]  = is_full && !hw_mul_r;
  assign irq_set[`IMU_IRQ_STEP]  = (op == imu_pkg::IMU_OP_STEP);
  assign irq_set[`IMU_IRQ_HWMUL] = is_full && hw_mul_r;
  assign irq_clr = (wr_fire && awaddr_r == `IMU_ADDR_IRQ_CLR &&
                    wstrb_r[0]) ? wdata_r[2:0] : 3'h0;
  // New events win over a clear in the same cycle
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= `IMU_IRQ_RST;
      irq_en_r   <= `IMU_IRQ_RST;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_fire && awaddr_r == `IMU_ADDR_IRQ_EN) begin
        irq_en_r <= en_merged[2:0];
        irq      <= |(irq_stat_nxt & en_merged[2:0]);
      end else begin
        irq <= |(irq_stat_nxt & irq_en_r);
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  full_trap_a: assert property (is_full && !hw_mul_r |=> trap_valid &&
      !result_valid) else $error("full multiply did not trap");
  ptr_load_a: assert property (is_full && !hw_mul_r |=>
      indirect_ptr_first == $past(src1_field) &&
      indirect_ptr_second == $past(src2_field) &&
      indirect_ptr_third == $past(dst_field))
    else $error("pointers not loaded on trap");
  lo_prod_a: assert property (op == imu_pkg::IMU_OP_MUL_LO && hw_mul_r |=>
      $signed(result_data) == $past($signed(first_source_value) *
                                    $signed(second_source_value)))
    else $error("low product wrong");
  hi_signed_a: assert property (op == imu_pkg::IMU_OP_MUL_HI_S && hw_mul_r
      |=> result_valid && {result_data, 32'h0} ==
      $past({{32{first_source_value[31]}}, first_source_value} *
            {{32{second_source_value[31]}}, second_source_value}) -
      {32'h0, $past(first_source_value * second_source_value)})
    else $error("signed high product wrong");
  hi_unsigned_a: assert property (op == imu_pkg::IMU_OP_MUL_HI_U &&
      hw_mul_r |=> {result_data, 32'h0} ==
      $past({32'h0, first_source_value} * {32'h0, second_source_value})
      - {32'h0, $past(first_source_value * second_source_value)})
    else $error("unsigned high product wrong");
  trap_code_a: assert property (issue_valid && opc == `IMU_OPC_MUL_HI_U &&
      !hw_mul_r |=> trap_code == imu_pkg::IMU_TRAP_MUL_HI_U)
    else $error("wrong trap code");
  step_zero_a: assert property (op == imu_pkg::IMU_OP_STEP && !q_r[0] |=>
      result_data == {1'b0, $past(src2_val[31:1])} && !flags[`IMU_FLAG_C])
    else $error("step added a nonzero word");
  step_q_a: assert property (op == imu_pkg::IMU_OP_STEP |=>
      q_r[30:0] == $past(q_r[31:1]) && result_valid && flags_valid)
    else $error("Q not shifted");
  imm_step_a: assert property (issue_valid && opc == `IMU_OPC_STEP_IMM &&
      !q_r[0] |=> result_data == {25'h0, $past(src2_field[7:1])} &&
      result_target == $past(dst_field)) else $error("immediate step wrong");
  flags_hold_a: assert property (is_full |=> flags == $past(flags))
    else $error("full multiply changed flags");

  trap_seen_c: cover property (is_full && !hw_mul_r ##1 trap_valid);
  step_carry_c: cover property (op == imu_pkg::IMU_OP_STEP && step_sum[32]);
  hw_mul_c: cover property (is_full && hw_mul_r ##1 result_valid);
  irq_c: cover property (!irq ##1 irq);

endmodule

// >>> imu_issue_model.sv
// Issue-side model: register file feeding the multiply unit
`timescale 1ns/1ps
module imu_issue_model (
  input  wire logic        aclk,
  output logic             issue_valid,
  output logic [31:0]      issue_instr,
  output logic [31:0]      first_source_value,
  output logic [31:0]      second_source_value,
  input  wire logic        result_valid,
  input  wire logic [7:0]  result_target,
  input  wire logic [31:0] result_data
);
  logic [31:0] regs [0:255];
  initial begin
    issue_valid = 1'b0;
    issue_instr = 32'h0000_0000;
    first_source_value = 32'h0000_0000;
    second_source_value = 32'h0000_0000;
    for (int i = 0; i < 256; i++) regs[i] = 32'h5a5a_0000 + 32'(i);
  end
  // Issues one instruction with the contents of its named registers
  task automatic send(input logic [31:0] instr);
    @(posedge aclk);
    issue_valid <= 1'b1;
    issue_instr <= instr;
    first_source_value <= regs[instr[15:8]];
    second_source_value <= regs[instr[7:0]];
  endtask
  // Stale operands are scrambled once nothing is issued
  task automatic idle();
    @(posedge aclk);
    issue_valid <= 1'b0;
    issue_instr <= ~issue_instr;
    first_source_value <= ~first_source_value;
    second_source_value <= ~second_source_value;
  endtask
  always @(posedge aclk) if (result_valid) regs[result_target] <= result_data;
endmodule

// >>> imu_core_test.sv
// Self-checking bench for the integer multiply unit
`timescale 1ns/1ps
`include "imu_defines.svh"
module imu_core_test;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, issue_valid, result_valid, flags_valid;
  logic        trap_valid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, trap_code;
  logic [31:0] issue_instr, first_source_value, second_source_value;
  logic [31:0] result_data, d, q, er, a, b;
  logic [7:0]  result_target, indirect_ptr_first;
  logic [7:0]  indirect_ptr_second, indirect_ptr_third;
  logic [3:0]  flags, ef;
  logic [1:0]  r;
  logic [67:0] m;
  logic [7:0]  opc [3] = '{`IMU_OPC_MUL_LO, `IMU_OPC_MUL_HI_S,
                           `IMU_OPC_MUL_HI_U};
  logic [63:0] ps, pu;
  int          mismatches = 0, samples_checked = 0;
  always #2.5 aclk = ~aclk;
  imu_core u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .first_source_value(first_source_value),
    .second_source_value(second_source_value),
    .result_valid(result_valid), .result_target(result_target),
    .result_data(result_data), .flags_valid(flags_valid), .flags(flags),
    .trap_valid(trap_valid), .trap_code(trap_code),
    .indirect_ptr_first(indirect_ptr_first),
    .indirect_ptr_second(indirect_ptr_second),
    .indirect_ptr_third(indirect_ptr_third), .irq(irq));
  imu_issue_model u_part (
    .aclk(aclk), .issue_valid(issue_valid), .issue_instr(issue_instr),
    .first_source_value(first_source_value),
    .second_source_value(second_source_value),
    .result_valid(result_valid), .result_target(result_target),
    .result_data(result_data));
  task automatic finish_test();
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic timeout();
    mismatches++;
    finish_test();
  endtask
  // ==========================================================
  // Register bus master
  task automatic wr(input logic [7:0] ad, input logic [31:0] da,
                    output logic [1:0] rs);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= da;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~ad;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~da;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 50) timeout();
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] da,
                    output logic [1:0] rs);
    int n;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~ad;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        da = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 50) timeout();
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] ex);
    logic [31:0] v;
    logic [1:0]  s;
    rd(ad, v, s);
    check("read data", v, ex);
    check("read resp", {30'h0, s}, {30'h0, `IMU_RESP_OKAY});
  endtask
  // One instruction, outputs settled after the edge that takes it
  task automatic issue1(input logic [31:0] ins);
    u_part.send(ins);
    u_part.idle();
    #1;
  endtask
  function automatic logic [67:0] step_model(input logic [31:0] sa, sb, sq);
    logic [31:0] ae, rr;
    logic [32:0] s;
    ae = sq[0] ? sa : 32'h0;
    s = {1'b0, ae} + {1'b0, sb};
    rr = {s[32], s[31:1]};
    step_model = {(ae[31] == sb[31]) && (s[31] != sb[31]), rr[31],
                  rr == 32'h0, s[32], rr, s[0], sq[31:1]};
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 7; k++) rd_chk(8'(4 * k), 32'h0);
    rd(8'h40, d, r);
    check("unmapped data", d, 32'h0);
    check("unmapped rd resp", {30'h0, r}, {30'h0, `IMU_RESP_SLVERR});
    wr(8'h40, 32'hffff_ffff, r);
    check("unmapped wr resp", {30'h0, r}, {30'h0, `IMU_RESP_SLVERR});
    wr(`IMU_ADDR_IRQ_EN, 32'h1, r);
    issue1(32'h0155_6677);
    check("unknown op", {result_valid, trap_valid, flags_valid}, 3'h0);
    for (int k = 0; k < 3; k++) begin
      issue1({opc[k], 8'h10 + 8'(k), 8'h21, 8'h32 + 8'(k)});
      check("trap pulse", {trap_valid, result_valid}, 2'h2);
      check("trap code", {30'h0, trap_code}, k);
      check("ptr first", {24'h0, indirect_ptr_first}, 32'h21);
      check("ptr second", {24'h0, indirect_ptr_second}, 32'h32 + k);
      check("ptr third", {24'h0, indirect_ptr_third}, 32'h10 + k);
      check("trap flags", {28'h0, flags}, 32'h0);
      @(posedge aclk);
      #1;
      check("trap end", {31'h0, trap_valid}, 32'h0);
      check("irq on", {31'h0, irq}, 32'h1);
      rd_chk(`IMU_ADDR_IRQ_STAT, 32'h1);
      rd_chk(`IMU_ADDR_IPTR, {8'h0, 8'h10 + 8'(k), 8'h21, 8'h32 + 8'(k)});
      wr(`IMU_ADDR_IRQ_CLR, 32'h1, r);
      @(posedge aclk);
      #1;
      check("irq off", {31'h0, irq}, 32'h0);
    end
    wr(`IMU_ADDR_CTRL, 32'h1, r);
    a = 32'hffff_fffe;
    b = 32'h0000_0003;
    u_part.regs[8'h21] = a;
    u_part.regs[8'h32] = b;
    ps = {{32{a[31]}}, a} * {{32{b[31]}}, b};
    pu = {32'h0, a} * {32'h0, b};
    for (int k = 0; k < 3; k++) begin
      issue1({opc[k], 8'h40, 8'h21, 8'h32});
      check("hw pulse", {trap_valid, result_valid}, 2'h1);
      check("hw target", {24'h0, result_target}, 32'h40);
      check("hw data", result_data,
            k == 0 ? ps[31:0] : k == 1 ? ps[63:32] : pu[63:32]);
      check("hw flags", {27'h0, flags_valid, flags}, 32'h0);
    end
    wr(`IMU_ADDR_CTRL, 32'h0, r);
    a = 32'h8000_0001;
    b = 32'h7fff_ffff;
    u_part.regs[8'h21] = a;
    u_part.regs[8'h32] = b;
    u_part.regs[8'h01] = 32'hdead_beef;
    q = 32'h0000_0005;
    wr(`IMU_ADDR_STEP_Q, q, r);
    for (int i = 0; i < 6; i++) begin
      if (i < 4) u_part.send({`IMU_OPC_STEP_REG, 8'h50, 8'h21, 8'h32});
      else if (i == 4) u_part.send({`IMU_OPC_STEP_IMM, 8'h51, 8'h21, 8'h01});
      else u_part.idle();
      if (i > 0) begin
        #1;
        check("step valid", {trap_valid, result_valid, flags_valid}, 3'h3);
        check("step target", {24'h0, result_target},
              i == 5 ? 32'h51 : 32'h50);
        check("step data", result_data, er);
        check("step flags", {28'h0, flags}, {28'h0, ef});
      end
      // Only the five issued steps advance the model
      if (i < 5) begin
        m = step_model(a, i == 4 ? 32'h0000_0001 : b, q);
        ef = m[67:64];
        er = m[63:32];
        q = m[31:0];
      end
    end
    rd_chk(`IMU_ADDR_STEP_Q, q);
    rd_chk(`IMU_ADDR_IRQ_STAT, 32'h6);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(`IMU_ADDR_IRQ_EN, 32'h2, r);
    rd_chk(`IMU_ADDR_IRQ_EN, 32'h2);
    check("irq enabled", {31'h0, irq}, 32'h1);
    wr(`IMU_ADDR_IRQ_CLR, 32'h7, r);
    rd_chk(`IMU_ADDR_IRQ_STAT, 32'h0);
    check("irq cleared", {31'h0, irq}, 32'h0);
    // A trapping multiply after the steps must keep the last step's flags
    issue1({opc[1], 8'h10, 8'h21, 8'h32});
    check("flags kept", {28'h0, flags}, {28'h0, ef});
    finish_test();
  end
endmodule
